// ===== hdl/mpio_pkg.sv
`default_nettype none
package mpio_pkg;
  localparam logic [7:0] MPIO_WIDE_DATA = 8'h00;
  localparam logic [7:0] MPIO_WIDE_CONFIG = 8'h04;
  localparam logic [7:0] MPIO_WIDE_PINS = 8'h08;
  localparam logic [7:0] MPIO_SPECIAL_DATA = 8'h0C;
  localparam logic [7:0] MPIO_SPECIAL_CONFIG = 8'h10;
  localparam logic [7:0] MPIO_SPECIAL_PINS = 8'h14;
  localparam logic [7:0] MPIO_NIBBLE_DATA = 8'h18;
  localparam logic [7:0] MPIO_NIBBLE_CONFIG = 8'h1C;
  localparam logic [7:0] MPIO_NIBBLE_PINS = 8'h20;
  localparam logic [7:0] MPIO_INPUT_PINS = 8'h24;
  localparam logic [7:0] MPIO_OUTPUT_DATA = 8'h28;
  localparam logic [7:0] MPIO_REG_RESET = 8'h00;
  localparam logic [7:0] MPIO_OUT_RESET = 8'hFF;
  localparam logic [7:0] MPIO_SPECIAL_CFG_MASK = 8'h3F;
  localparam logic [7:0] MPIO_NIBBLE_MASK = 8'h0F;
  localparam int MPIO_HALT_BIT = 7;
  localparam logic [1:0] MPIO_RESP_OKAY = 2'b00;
  localparam logic [1:0] MPIO_RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// ===== hdl/mpio_ports.sv
`default_nettype none
module mpio_ports
  import mpio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] wide_in,
  output logic [7:0] wide_out,
  output logic [7:0] wide_oe,
  output logic [7:0] wide_pullup,
  input wire logic [7:0] special_in,
  output logic [7:0] special_out,
  output logic [7:0] special_oe,
  output logic [7:0] special_pullup,
  input wire logic [3:0] nibble_in,
  output logic [3:0] nibble_out,
  output logic [3:0] nibble_oe,
  output logic [3:0] nibble_pullup,
  input wire logic [7:0] input_port_in,
  output logic [7:0] output_port,
  output logic halt_req,
  output logic external_interrupt_input,
  output logic timer_io_pin,
  output logic serial_data_in,
  output logic serial_clock_pin,
  output logic oscillator_output_pin
);
  logic [7:0] wide_data, wide_config, special_data, special_config;
  logic [3:0] nibble_data, nibble_config;
  logic [7:0] wide_s1, wide_s2, special_s1, special_s2, input_s1, input_s2;
  logic [3:0] nibble_s1, nibble_s2;
  logic restart_prev;
  logic [7:0] aw_addr, ar_addr;
  logic aw_held, w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write, restart_rise;
  logic [7:0] wbyte;
  logic [31:0] next_rdata;
  logic next_rok;

  // Two flops on every pin input; only the second stage is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {wide_s1, wide_s2, special_s1, special_s2} <= '0;
      {input_s1, input_s2, nibble_s1, nibble_s2} <= '0;
    end else begin
      wide_s1 <= wide_in;
      wide_s2 <= wide_s1;
      special_s1 <= special_in;
      special_s2 <= special_s1;
      nibble_s1 <= nibble_in;
      nibble_s2 <= nibble_s1;
      input_s1 <= input_port_in;
      input_s2 <= input_s1;
    end
  end

  // Write channel: address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= MPIO_RESP_OKAY;
      // Readies are flops so every bus output leaves a register
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr[7:2] <= MPIO_OUTPUT_DATA[7:2] && aw_addr[1:0] == 2'b00)
                       ? MPIO_RESP_OKAY : MPIO_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wbyte = w_data[7:0];

  // Edge on the restart pin, seen only from the synchronised stage
  assign restart_rise = special_s2[MPIO_HALT_BIT] && !restart_prev;

  // Port registers; only byte lane 0 is stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wide_data <= MPIO_REG_RESET;
      wide_config <= MPIO_REG_RESET;
      special_data <= MPIO_REG_RESET;
      special_config <= MPIO_REG_RESET;
      nibble_data <= MPIO_REG_RESET[3:0];
      nibble_config <= MPIO_REG_RESET[3:0];
      output_port <= MPIO_OUT_RESET;
      restart_prev <= 1'b0;
    end else begin
      restart_prev <= special_s2[MPIO_HALT_BIT];
      if (do_write && w_strb[0]) begin
        case (aw_addr)
          MPIO_WIDE_DATA: wide_data <= wbyte;
          MPIO_WIDE_CONFIG: wide_config <= wbyte;
          MPIO_SPECIAL_DATA: special_data <= wbyte;
          MPIO_SPECIAL_CONFIG: special_config <= wbyte & MPIO_SPECIAL_CFG_MASK;
          MPIO_NIBBLE_DATA: nibble_data <= wbyte[3:0];
          MPIO_NIBBLE_CONFIG: nibble_config <= wbyte[3:0];
          MPIO_OUTPUT_DATA: output_port <= wbyte;
          default: ;
        endcase
      end
      // Restart clears halt bit only if already set; then a same-cycle software write of the bit loses
      if (special_data[MPIO_HALT_BIT] && restart_rise) begin
        special_data[MPIO_HALT_BIT] <= 1'b0;
      end
    end
  end
  assign halt_req = special_data[MPIO_HALT_BIT];

  // Pin drivers: config selects drive, data selects level or pull-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {wide_out, wide_oe, wide_pullup} <= '0;
      {special_out, special_oe, special_pullup} <= '0;
      {nibble_out, nibble_oe, nibble_pullup} <= '0;
    end else begin
      wide_oe <= wide_config;
      wide_out <= wide_config & wide_data;
      wide_pullup <= ~wide_config & wide_data;
      nibble_oe <= nibble_config;
      nibble_out <= nibble_config & nibble_data;
      nibble_pullup <= ~nibble_config & nibble_data;
      special_oe <= special_config & MPIO_SPECIAL_CFG_MASK;
      special_out <= special_config & special_data & MPIO_SPECIAL_CFG_MASK;
      special_pullup <= ~special_config & special_data & MPIO_SPECIAL_CFG_MASK;
    end
  end

  // Alternate functions fed from synchronised pins; bits 1, 2 and 4 feed none
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      external_interrupt_input <= 1'b0;
      timer_io_pin <= 1'b0;
      serial_clock_pin <= 1'b0;
      serial_data_in <= 1'b0;
      oscillator_output_pin <= 1'b0;
    end else begin
      external_interrupt_input <= special_s2[0];
      timer_io_pin <= special_s2[3];
      serial_clock_pin <= special_s2[5];
      serial_data_in <= special_s2[6];
      oscillator_output_pin <= special_s2[7];
    end
  end

  // Read path; unimplemented upper bits read as zero
  always_comb begin
    next_rdata = '0;
    next_rok = 1'b1;
    case (s_axi_araddr)
      MPIO_WIDE_DATA: next_rdata[7:0] = wide_data;
      MPIO_WIDE_CONFIG: next_rdata[7:0] = wide_config;
      MPIO_WIDE_PINS: next_rdata[7:0] = wide_s2;
      MPIO_SPECIAL_DATA: next_rdata[7:0] = special_data;
      MPIO_SPECIAL_CONFIG: next_rdata[7:0] = special_config & MPIO_SPECIAL_CFG_MASK;
      MPIO_SPECIAL_PINS: next_rdata[7:0] = special_s2;
      MPIO_NIBBLE_DATA: next_rdata[3:0] = nibble_data;
      MPIO_NIBBLE_CONFIG: next_rdata[3:0] = nibble_config;
      MPIO_NIBBLE_PINS: next_rdata[3:0] = nibble_s2;
      MPIO_INPUT_PINS: next_rdata[7:0] = input_s2;
      MPIO_OUTPUT_DATA: next_rdata[7:0] = output_port;
      default: next_rok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= MPIO_RESP_OKAY;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rok ? MPIO_RESP_OKAY : MPIO_RESP_SLVERR;
      s_axi_arready <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  a_special_cfg_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready && s_axi_araddr == MPIO_SPECIAL_CONFIG)
    |-> s_axi_rdata[7:6] == 2'b00) else $error("special config upper bits nonzero");
  a_input_never_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    special_oe[7:6] == 2'b00) else $error("input-only pin driven");
  a_out_reset_high: assert property (@(posedge aclk)
    !aresetn |=> output_port == MPIO_OUT_RESET) else $error("output port not high");
  a_reset_clears: assert property (@(posedge aclk)
    !aresetn |=> wide_oe == 8'h00 && special_oe == 8'h00 && nibble_oe == 4'h0)
    else $error("ports not released by reset");
  a_drive_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (wide_oe == $past(wide_config) && wide_pullup == ($past(~wide_config & wide_data))))
    else $error("wide decode wrong");
  a_special_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    (special_out & ~special_oe) == 8'h00 && (special_pullup & special_oe) == 8'h00)
    else $error("special drives high while off");
  a_halt_set: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && w_strb[0] && aw_addr == MPIO_SPECIAL_DATA && wbyte[7] && !restart_rise
    |=> halt_req) else $error("halt not requested");
  a_halt_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_req && restart_rise |=> !halt_req) else $error("halt not cleared");
  a_nibble_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  a_pins_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == MPIO_WIDE_PINS
    |=> s_axi_rdata[7:0] == $past(wide_s2)) else $error("pin read wrong");

  // Register, decode, read-path and write-response checks
  a_wide_write: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && w_strb[0] && aw_addr == MPIO_WIDE_DATA
    |=> wide_data == $past(wbyte))
    else $error("wide data write lost");
  a_special_cfg_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && w_strb[0] && aw_addr == MPIO_SPECIAL_CONFIG
    |=> special_config == ($past(wbyte) & MPIO_SPECIAL_CFG_MASK))
    else $error("special config mask wrong");
  a_nibble_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (nibble_oe == $past(nibble_config)
    && nibble_pullup == $past(~nibble_config & nibble_data)))
    else $error("nibble decode wrong");
  a_wide_level: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (wide_out == $past(wide_config & wide_data)
    && nibble_out == $past(nibble_config & nibble_data)))
    else $error("driven level wrong");
  a_special_pull: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (special_pullup == ($past(~special_config & special_data) & MPIO_SPECIAL_CFG_MASK)
    && special_out == ($past(special_config & special_data) & MPIO_SPECIAL_CFG_MASK)))
    else $error("special decode wrong");
  a_alt_functions: assert property (@(posedge aclk) disable iff (!aresetn)
    {oscillator_output_pin, serial_data_in, serial_clock_pin, timer_io_pin,
    external_interrupt_input} == $past({special_s2[7:5], special_s2[3], special_s2[0]}))
    else $error("alternate function wrong");
  a_special_pins: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == MPIO_SPECIAL_PINS
    |=> s_axi_rdata[7:0] == $past(special_s2))
    else $error("special pin read wrong");
  a_input_read: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == MPIO_INPUT_PINS
    |=> s_axi_rdata[7:0] == $past(input_s2))
    else $error("input port read wrong");
  a_nibble_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && (s_axi_araddr == MPIO_NIBBLE_DATA
    || s_axi_araddr == MPIO_NIBBLE_CONFIG || s_axi_araddr == MPIO_NIBBLE_PINS)
    |=> s_axi_rdata[7:4] == 4'h0) else $error("nibble upper bits set");
  a_reset_regs: assert property (@(posedge aclk)
    !aresetn |=> wide_data == 8'h00 && wide_config == 8'h00 && special_data == 8'h00
    && special_config == 8'h00 && nibble_data == 4'h0 && nibble_config == 4'h0)
    else $error("registers not cleared by reset");
  a_halt_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_req && !restart_rise && !(do_write && w_strb[0] && aw_addr == MPIO_SPECIAL_DATA)
    |=> halt_req)
    else $error("halt dropped early");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && aw_addr == MPIO_WIDE_CONFIG
    |=> s_axi_bvalid && s_axi_bresp == MPIO_RESP_OKAY)
    else $error("write response missing");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read response missing");
endmodule
`default_nettype wire

// ===== dv/mpio_pin_model.sv
`default_nettype none
module mpio_pin_model #(parameter int W = 8) (
  input wire logic clk,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] pull_en,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [W-1:0] last = '0;
  // Floating lines flip each cycle so a stale level never reads as valid
  always @(posedge clk) last <= level;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i]) level[i] = out[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else if (pull_en[i]) level[i] = 1'b1;
      else level[i] = ~last[i];
    end
  end
endmodule
`default_nettype wire

// ===== dv/mcu_parallel_io_ports_bench.sv
`default_nettype none
module mcu_parallel_io_ports_bench import mpio_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, halt_req, ext_external_interrupt_input;
  logic timer_pin, sck_pin, sdi_pin, osc_pin;
  logic [3:0] wstrb = 4'hF, n_en = '0, n_ext = '0;
  logic [7:0] awaddr = '0, araddr = '0, in_port = 8'h5A;
  logic [31:0] wdata = '0, rdata, rd_val;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] w_oe, w_out, w_pu, w_lvl, s_oe, s_out, s_pu, s_lvl, out_port;
  logic [7:0] w_ext = '0, w_en = '0, s_ext = '0, s_en = 8'hC0;
  logic [3:0] n_oe, n_out, n_pu, n_lvl;
  int errors = 0, tests_run = 0;
  // Write address, data, read address, expected read
  logic [31:0] rows [7] = '{32'h04FF04FF, 32'h00A500A5, 32'h10FF103F, 32'h0C3C0C3C,
    32'h18FF180F, 32'h1C5A1C0A, 32'h28962896};
  always #50 aclk = ~aclk;
  mpio_ports i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wide_in(w_lvl),
    .wide_out(w_out), .wide_oe(w_oe), .wide_pullup(w_pu), .special_in(s_lvl),
    .special_out(s_out), .special_oe(s_oe), .special_pullup(s_pu), .nibble_in(n_lvl),
    .nibble_out(n_out), .nibble_oe(n_oe), .nibble_pullup(n_pu), .input_port_in(in_port),
    .output_port(out_port), .halt_req(halt_req), .external_interrupt_input(ext_external_interrupt_input),
    .timer_io_pin(timer_pin), .serial_data_in(sdi_pin), .serial_clock_pin(sck_pin),
    .oscillator_output_pin(osc_pin));
  mpio_pin_model #(.W(8)) i_wide (.clk(aclk), .oe(w_oe), .out(w_out), .pull_en(w_pu),
    .ext_en(w_en), .ext_val(w_ext), .level(w_lvl));
  mpio_pin_model #(.W(8)) i_special (.clk(aclk), .oe(s_oe), .out(s_out), .pull_en(s_pu),
    .ext_en(s_en), .ext_val(s_ext), .level(s_lvl));
  mpio_pin_model #(.W(4)) i_nibble (.clk(aclk), .oe(n_oe), .out(n_out), .pull_en(n_pu),
    .ext_en(n_en), .ext_val(n_ext), .level(n_lvl));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Each request stands until its ready is seen high at a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_val = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge aclk);
    chk("out_rst", out_port, 32'hFF);
    aresetn <= 1'b1;
    rd(MPIO_WIDE_DATA);
    chk("wide_data_rst", rd_val, 32'h0);
    chk("wide_oe_rst", w_oe | w_pu, 32'h0);
    for (int i = 0; i < 7; i++) begin
      wr(rows[i][31:24], rows[i][23:16]);
      chk("wr_resp", resp, MPIO_RESP_OKAY);
      rd(rows[i][15:8]);
      chk("rd_back", rd_val, rows[i][7:0]);
    end
    repeat (3) @(posedge aclk);
    chk("wide_drive", {w_oe, w_out}, 32'hFFA5);
    chk("special_drive", {s_oe, s_out & s_oe, s_pu}, 32'h3F3C00);
    chk("nibble_drive", {n_oe, n_out & n_oe, n_pu}, 32'hAA5);
    chk("out_port", out_port, 32'h96);
    wstrb <= 4'hE;
    wr(MPIO_OUTPUT_DATA, 8'h11);
    wstrb <= 4'hF;
    rd(MPIO_OUTPUT_DATA);
    chk("strobe_off", rd_val, 32'h96);
    wr(MPIO_NIBBLE_CONFIG, 8'h00);
    n_ext <= 4'h6;
    n_en <= 4'hF;
    repeat (4) @(posedge aclk);
    rd(MPIO_NIBBLE_PINS);
    chk("nibble_pins", rd_val, 32'h6);
    n_en <= 4'h0;
    wr(MPIO_NIBBLE_CONFIG, 8'h0F);
    repeat (4) @(posedge aclk);
    chk("nibble_all_out", {n_oe, n_out}, 32'hFF);
    rd(MPIO_NIBBLE_PINS);
    chk("nibble_driven", rd_val, 32'hF);
    wr(MPIO_WIDE_CONFIG, 8'h00);
    wr(MPIO_WIDE_DATA, 8'h0F);
    w_ext <= 8'h30;
    w_en <= 8'hF0;
    repeat (4) @(posedge aclk);
    chk("wide_float", {w_oe, w_pu}, 32'h000F);
    rd(MPIO_WIDE_PINS);
    chk("wide_pins", rd_val, 32'h3F);
    wr(8'h40, 8'hFF);
    chk("bad_wr", resp, MPIO_RESP_SLVERR);
    rd(8'h01);
    chk("bad_rd", resp, MPIO_RESP_SLVERR);
    wr(MPIO_SPECIAL_CONFIG, 8'h00);
    s_en <= 8'hFF;
    s_ext <= 8'h01;
    wr(MPIO_SPECIAL_DATA, 8'h80);
    repeat (2) @(posedge aclk);
    chk("halt_set", halt_req, 32'h1);
    chk("external_interrupt_input_pin", ext_external_interrupt_input, 32'h1);
    s_ext <= 8'h81;
    repeat (6) @(posedge aclk);
    chk("halt_exit", halt_req, 32'h0);
    chk("alt_fn", {osc_pin, sdi_pin, sck_pin, timer_pin, ext_external_interrupt_input}, 32'h11);
    rd(MPIO_SPECIAL_DATA);
    chk("halt_bit", rd_val, 32'h0);
    s_ext <= 8'hE9;
    repeat (4) @(posedge aclk);
    chk("alt_fn_all", {osc_pin, sdi_pin, sck_pin, timer_pin, ext_external_interrupt_input}, 32'h1F);
    rd(MPIO_SPECIAL_PINS);
    chk("special_pins", rd_val, 32'hE9);
    rd(MPIO_INPUT_PINS);
    chk("input_port", rd_val, 32'h5A);
    // Second reset in mid-run must restore the power-up state
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("rst2", {out_port, w_pu, s_pu}, 32'hFF0000);
    aresetn <= 1'b1;
    rd(MPIO_WIDE_CONFIG);
    chk("cfg_after_rst2", rd_val, 32'h0);
    rd(MPIO_OUTPUT_DATA);
    chk("out_after_rst2", rd_val, 32'hFF);
    complete_run();
  end
endmodule
`default_nettype wire
